//--- logic/adc_calibration_control.sv
// Overview of operation
// - Two system sets A/B, select applies A/B/none
// - Calibrations use current rate, gain, filter settings
// - Gain coefficient unsigned, 0x800000 is unity
// - Offset coefficient two's complement, saturating range
// - Offset coefficient step is half output LSB
// - Eight internal gain coefficients, one per gain
// - Amplifier gain calibration updates selected-gain coefficient only
// - Conversion applies coefficient of selected gain
// - Self-calibration updates internal offset and unity gain
// - Command 000: two conversions, offset then unity gain
// - Command 001: one conversion, selected gain coefficient
// - System offset calibration cancels applied zero input
// - System gain calibration scales applied full scale
// - Host may write every coefficient directly
// - Commands 100/110 system offset into A/B
// - Commands 101/111 system gain into A/B
// - Result is sysgain*((raw-off)*gain - sysoff)
// - Offsets reset to zero, gains to unity
`timescale 1ns/1ps
`default_nettype none
module adc_calibration_control
  import cal_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  output logic [23:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [2:0] amplifier_gain_setting,
  input wire logic conv_valid,
  input wire logic [23:0] conv_data,
  output logic conv_start,
  output logic [1:0] cal_input_route,
  output logic cal_busy,
  output logic [23:0] data_out,
  output logic data_valid
);
  typedef struct packed {
    cal_state_e state;
    logic [2:0] cmd;
    logic phase;
    logic [2:0] gidx;
    logic got_raw;
    logic [23:0] self_off;
    logic [7:0][23:0] self_gain;
    logic [23:0] system_offset_set_a;
    logic [23:0] system_gain_set_a;
    logic [23:0] system_offset_set_b;
    logic [23:0] system_gain_set_b;
    logic [1:0] system_set_select;
    logic [23:0] meas;
    logic [46:0] num;
    logic [24:0] rem;
    logic [23:0] quo;
    logic ovf;
    logic [5:0] cnt;
    logic [23:0] rdata;
    logic rvalid;
    logic conv_start;
    route_e route;
    logic busy;
    logic [23:0] data_out;
    logic data_valid;
  } ctrl_s;

  ctrl_s st_reg;
  ctrl_s st_next;
  corr_if cif();

  logic use_a;
  logic use_b;
  logic scale_cal;
  logic [2:0] rd_idx;
  logic [2:0] wr_idx;
  logic [24:0] trial;
  logic [23:0] off_coef;
  logic [23:0] gain_coef;
  logic offset_kind;

  coef_apply u_apply (
    .clk(clk),
    .resetn(resetn),
    .cif(cif)
  );

  // Coefficients fed to the pipeline depend on what is being measured
  assign scale_cal = st_reg.busy && st_reg.cmd[2] && st_reg.cmd[0];
  assign use_a = st_reg.busy ? (scale_cal && !st_reg.cmd[1]) : (st_reg.system_set_select == SET_A);
  assign use_b = st_reg.busy ? (scale_cal && st_reg.cmd[1]) : (st_reg.system_set_select == SET_B);
  assign cif.raw = conv_data;
  assign cif.raw_valid = conv_valid;
  assign cif.self_off = (st_reg.busy && st_reg.cmd == CMD_SELF && !st_reg.phase) ? OFFSET_ZERO : st_reg.self_off;
  assign cif.self_gain = (st_reg.busy && (st_reg.cmd == CMD_SELF || st_reg.cmd == CMD_AMP)) ? GAIN_UNITY :
                         st_reg.self_gain[st_reg.busy ? st_reg.gidx : amplifier_gain_setting];
  assign cif.sys_off = use_a ? st_reg.system_offset_set_a :
                       use_b ? st_reg.system_offset_set_b : OFFSET_ZERO;
  // System gain is held at unity during every calibration, not only while its own value is being measured
  assign cif.sys_gain = st_reg.busy ? GAIN_UNITY :
                        use_a ? st_reg.system_gain_set_a :
                        use_b ? st_reg.system_gain_set_b : GAIN_UNITY;

  assign rd_idx = 3'(reg_addr[2:0] - 3'h2);
  assign wr_idx = 3'(reg_addr[2:0] - 3'h2);
  assign trial = {st_reg.rem[23:0], st_reg.num[46]};
  // A measurement in LSB units becomes a half-LSB coefficient
  assign off_coef = sat24({{7{st_reg.meas[23]}}, st_reg.meas, 1'b0});
  // Zero or negative measurement gives the top code rather than a wrapped one
  assign gain_coef = st_reg.ovf ? GAIN_MAX : st_reg.quo;
  assign offset_kind = (st_reg.cmd == CMD_SELF && !st_reg.phase) ||
                       st_reg.cmd == CMD_ZERO_A || st_reg.cmd == CMD_ZERO_B;

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.conv_start = 1'b0;
    st_next.data_valid = 1'b0;

    if (reg_rd) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = 24'h00_0000;
      if (reg_addr >= ADDR_SELF_GAIN0 && reg_addr <= ADDR_SELF_GAIN7) begin
        st_next.rdata = st_reg.self_gain[rd_idx];
      end else begin
        unique case (reg_addr)
          ADDR_SELF_OFF: st_next.rdata = st_reg.self_off;
          ADDR_SYS_OFFSET_A: st_next.rdata = st_reg.system_offset_set_a;
          ADDR_SYSTEM_GAIN_SET_A: st_next.rdata = st_reg.system_gain_set_a;
          ADDR_SYS_OFFSET_B: st_next.rdata = st_reg.system_offset_set_b;
          ADDR_SYSTEM_GAIN_SET_B: st_next.rdata = st_reg.system_gain_set_b;
          ADDR_SET_SELECT: st_next.rdata = {22'h00_0000, st_reg.system_set_select};
          ADDR_STATUS: st_next.rdata = {23'h00_0000, st_reg.busy};
          default: st_next.rdata = 24'h00_0000;
        endcase
      end
    end

    // Host writes come first so a calibration store in the same cycle wins
    if (reg_wr) begin
      if (reg_addr >= ADDR_SELF_GAIN0 && reg_addr <= ADDR_SELF_GAIN7) begin
        st_next.self_gain[wr_idx] = reg_wdata;
      end else begin
        unique case (reg_addr)
          ADDR_SELF_OFF: st_next.self_off = reg_wdata;
          ADDR_SYS_OFFSET_A: st_next.system_offset_set_a = reg_wdata;
          ADDR_SYSTEM_GAIN_SET_A: st_next.system_gain_set_a = reg_wdata;
          ADDR_SYS_OFFSET_B: st_next.system_offset_set_b = reg_wdata;
          ADDR_SYSTEM_GAIN_SET_B: st_next.system_gain_set_b = reg_wdata;
          ADDR_SET_SELECT: st_next.system_set_select = reg_wdata[1:0];
          default: ;
        endcase
      end
    end

    unique case (st_reg.state)
      ST_IDLE: begin
        if (cif.result_valid) begin
          st_next.data_out = cif.result;
          st_next.data_valid = 1'b1;
        end
        // Codes 010 and 011 have no meaning and are dropped
        if (reg_wr && reg_addr == ADDR_CMD && reg_wdata[2:1] != 2'h1) begin
          st_next.cmd = reg_wdata[2:0];
          st_next.phase = 1'b0;
          st_next.gidx = amplifier_gain_setting;
          st_next.busy = 1'b1;
          st_next.state = ST_START;
          unique case (reg_wdata[2:0])
            CMD_SELF: st_next.route = ROUTE_INT_ZERO;
            CMD_AMP: st_next.route = ROUTE_INT_FULL;
            default: st_next.route = ROUTE_EXTERNAL;
          endcase
        end
      end
      ST_START: begin
        // The conversion engine runs with its own current settings
        st_next.conv_start = 1'b1;
        st_next.got_raw = 1'b0;
        st_next.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (conv_valid) begin
          st_next.got_raw = 1'b1;
        end
        if (st_reg.got_raw && cif.result_valid) begin
          st_next.meas = cif.result;
          if (offset_kind) begin
            st_next.state = ST_STORE;
          end else begin
            st_next.num = {FULL_SCALE, 23'h00_0000};
            st_next.rem = 25'h000_0000;
            st_next.quo = 24'h00_0000;
            st_next.ovf = cif.result[23];
            st_next.cnt = 6'h00;
            st_next.state = ST_DIVIDE;
          end
        end
      end
      ST_DIVIDE: begin
        // Full scale times 2^23 over the measured full scale
        if (trial >= {1'b0, st_reg.meas}) begin
          st_next.rem = trial - {1'b0, st_reg.meas};
          st_next.quo = {st_reg.quo[22:0], 1'b1};
        end else begin
          st_next.rem = trial;
          st_next.quo = {st_reg.quo[22:0], 1'b0};
        end
        st_next.num = {st_reg.num[45:0], 1'b0};
        st_next.ovf = st_reg.ovf | st_reg.quo[23];
        st_next.cnt = 6'(st_reg.cnt + 6'h01);
        if (st_reg.cnt == DIV_LAST) begin
          st_next.state = ST_STORE;
        end
      end
      ST_STORE: begin
        st_next.state = ST_IDLE;
        st_next.busy = 1'b0;
        st_next.route = ROUTE_NORMAL;
        unique case (st_reg.cmd)
          CMD_SELF: begin
            if (!st_reg.phase) begin
              st_next.self_off = off_coef;
              st_next.phase = 1'b1;
              st_next.route = ROUTE_INT_FULL;
              st_next.busy = 1'b1;
              st_next.state = ST_START;
            end else begin
              st_next.self_gain[0] = gain_coef;
            end
          end
          CMD_AMP: st_next.self_gain[st_reg.gidx] = gain_coef;
          CMD_ZERO_A: st_next.system_offset_set_a = off_coef;
          CMD_ZERO_B: st_next.system_offset_set_b = off_coef;
          CMD_SCALE_A: st_next.system_gain_set_a = gain_coef;
          CMD_SCALE_B: st_next.system_gain_set_b = gain_coef;
          default: ;
        endcase
      end
      default: begin
        st_next.state = ST_IDLE;
        st_next.busy = 1'b0;
        st_next.route = ROUTE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.self_off <= OFFSET_ZERO;
      st_reg.self_gain <= {8{GAIN_UNITY}};
      st_reg.system_offset_set_a <= OFFSET_ZERO;
      st_reg.system_offset_set_b <= OFFSET_ZERO;
      st_reg.system_gain_set_a <= GAIN_UNITY;
      st_reg.system_gain_set_b <= GAIN_UNITY;
      st_reg.state <= ST_IDLE;
      st_reg.route <= ROUTE_NORMAL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign reg_rvalid = st_reg.rvalid;
  assign conv_start = st_reg.conv_start;
  assign cal_input_route = st_reg.route;
  assign cal_busy = st_reg.busy;
  assign data_out = st_reg.data_out;
  assign data_valid = st_reg.data_valid;
endmodule : adc_calibration_control
`default_nettype wire

//--- logic/coef_apply.sv
`timescale 1ns/1ps
`default_nettype none
module coef_apply
  import cal_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  corr_if.pipe cif
);
  typedef struct packed {
    logic v1;
    logic [25:0] s1;
    logic v2;
    logic [27:0] s2;
    logic v3;
    logic [28:0] s3;
    logic v4;
    logic [23:0] out;
  } pipe_s;

  pipe_s pipe_reg;
  pipe_s pipe_next;
  logic signed [50:0] prod_int;
  logic signed [53:0] prod_sys;

  // Work in half-LSB units until the last stage
  always_comb begin
    pipe_next = pipe_reg;
    pipe_next.v1 = cif.raw_valid;
    pipe_next.s1 = {cif.raw[23], cif.raw, 1'b0} - {{2{cif.self_off[23]}}, cif.self_off};
    prod_int = $signed(pipe_reg.s1) * $signed({1'b0, cif.self_gain});
    pipe_next.v2 = pipe_reg.v1;
    pipe_next.s2 = prod_int[50:23];
    pipe_next.v3 = pipe_reg.v2;
    pipe_next.s3 = {pipe_reg.s2[27], pipe_reg.s2} - {{5{cif.sys_off[23]}}, cif.sys_off};
    prod_sys = $signed(pipe_reg.s3) * $signed({1'b0, cif.sys_gain});
    pipe_next.v4 = pipe_reg.v3;
    pipe_next.out = sat24({{2{prod_sys[53]}}, prod_sys[53:24]});
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pipe_reg <= '0;
    end else begin
      pipe_reg <= pipe_next;
    end
  end

  assign cif.result = pipe_reg.out;
  assign cif.result_valid = pipe_reg.v4;
endmodule : coef_apply
`default_nettype wire

//--- pkg/cal_pkg.sv
`default_nettype none
package cal_pkg;
  localparam int COEF_W = 24;
  localparam int ADDR_W = 8;
  localparam int GAIN_FRAC = 23;
  localparam int DIV_STEPS = 47;
  localparam logic [5:0] DIV_LAST = 6'h2e;
  localparam logic [23:0] GAIN_UNITY = 24'h80_0000;
  localparam logic [23:0] GAIN_MAX = 24'hff_ffff;
  localparam logic [23:0] OFFSET_ZERO = 24'h00_0000;
  localparam logic [23:0] FULL_SCALE = 24'h7f_ffff;
  localparam logic [23:0] OFFSET_MOST_NEG = 24'h80_0000;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SELF_OFF = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_SELF_GAIN0 = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_SELF_GAIN7 = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_SYS_OFFSET_A = 8'h0a;
  localparam logic [ADDR_W-1:0] ADDR_SYSTEM_GAIN_SET_A = 8'h0b;
  localparam logic [ADDR_W-1:0] ADDR_SYS_OFFSET_B = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_SYSTEM_GAIN_SET_B = 8'h0d;
  localparam logic [ADDR_W-1:0] ADDR_SET_SELECT = 8'h0e;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0f;
  localparam logic [2:0] CMD_SELF = 3'h0;
  localparam logic [2:0] CMD_AMP = 3'h1;
  localparam logic [2:0] CMD_ZERO_A = 3'h4;
  localparam logic [2:0] CMD_SCALE_A = 3'h5;
  localparam logic [2:0] CMD_ZERO_B = 3'h6;
  localparam logic [2:0] CMD_SCALE_B = 3'h7;
  localparam logic [1:0] SET_NONE = 2'h0;
  localparam logic [1:0] SET_A = 2'h1;
  localparam logic [1:0] SET_B = 2'h2;

  typedef enum logic [1:0] {
    ROUTE_NORMAL = 2'h0,
    ROUTE_INT_ZERO = 2'h1,
    ROUTE_INT_FULL = 2'h2,
    ROUTE_EXTERNAL = 2'h3
  } route_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_WAIT = 3'h3,
    ST_DIVIDE = 3'h2,
    ST_STORE = 3'h6
  } cal_state_e;

  function automatic logic [23:0] sat24(input logic signed [31:0] v);
    if (v > $signed({8'h00, FULL_SCALE})) begin
      return FULL_SCALE;
    end else if (v < $signed({8'hff, OFFSET_MOST_NEG})) begin
      return OFFSET_MOST_NEG;
    end
    return v[23:0];
  endfunction : sat24
endpackage : cal_pkg
`default_nettype wire

//--- pkg/corr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface corr_if;
  logic [23:0] raw;
  logic raw_valid;
  logic [23:0] self_off;
  logic [23:0] self_gain;
  logic [23:0] sys_off;
  logic [23:0] sys_gain;
  logic [23:0] result;
  logic result_valid;
  modport ctrl (output raw, output raw_valid, output self_off, output self_gain, output sys_off, output sys_gain,
                input result, input result_valid);
  modport pipe (input raw, input raw_valid, input self_off, input self_gain, input sys_off, input sys_gain,
                output result, output result_valid);
endinterface : corr_if
`default_nettype wire

//--- testbench/cal_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cal_properties
  import cal_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [2:0] amplifier_gain_setting,
  input wire logic conv_valid,
  input wire logic [23:0] conv_data,
  input wire logic conv_start,
  input wire logic [1:0] cal_input_route,
  input wire logic cal_busy,
  input wire logic [23:0] data_out,
  input wire logic data_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic cmd_wr;
  assign cmd_wr = reg_wr && reg_addr == ADDR_CMD && !cal_busy;
  sequence launch_s;
    cal_busy ##1 (cal_busy && conv_start);
  endsequence
  sequence idle_conv_s;
    conv_valid && !cal_busy ##4 !cal_busy;
  endsequence
  read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read valid");
  cal_launch_a: assert property (cmd_wr && reg_wdata[2:1] != 2'b01 |=> launch_s) else $error("no launch");
  bad_code_a: assert property (cmd_wr && reg_wdata[2:1] == 2'b01 |=> !cal_busy) else $error("bad code ran");
  sys_route_a: assert property (cmd_wr && reg_wdata[2] |=> cal_input_route == 2'h3) else $error("sys route");
  self_route_a: assert property (cmd_wr && reg_wdata[2:0] == CMD_SELF |=> cal_input_route == 2'h1)
    else $error("self route");
  busy_route_a: assert property (cal_busy |-> cal_input_route != 2'h0) else $error("route dropped");
  idle_start_a: assert property (!cal_busy |-> !conv_start) else $error("idle conv start");
  conv_latency_a: assert property (idle_conv_s |=> data_valid) else $error("result missing");
  busy_drop_a: assert property (conv_valid && cal_busy ##4 cal_busy |=> !data_valid)
    else $error("result during calibration");
  out_cause_a: assert property (data_valid |-> $past(conv_valid, 5)) else $error("stray result");
endmodule : cal_properties
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cal_pkg::*;
;
  logic clk, resetn, reg_wr, reg_rd, conv_valid, reg_rvalid, conv_start, cal_busy, data_valid;
  logic [ADDR_W-1:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata, conv_data, data_out;
  logic [2:0] amplifier_gain_setting;
  logic [1:0] cal_input_route;
  int bad_count, num_checks;
  adc_calibration_control DUT (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .amplifier_gain_setting(amplifier_gain_setting), .conv_valid(conv_valid), .conv_data(conv_data),
    .conv_start(conv_start), .cal_input_route(cal_input_route), .cal_busy(cal_busy),
    .data_out(data_out), .data_valid(data_valid));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic summarize();
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [23:0] sat(input longint v);
    if (v > 64'sh7f_ffff) return 24'h7f_ffff;
    if (v < -64'sh80_0000) return 24'h80_0000;
    return v[23:0];
  endfunction : sat
  // Divide by zero or a negative reading pins the gain at the top code 0xffffff
  function automatic logic [23:0] gexp(input longint m);
    longint q;
    if (m <= 0) return 24'hff_ffff;
    q = (64'sh7f_ffff << 23) / m;
    return (q > 64'shff_ffff) ? 24'hff_ffff : q[23:0];
  endfunction : gexp
  function automatic logic [23:0] model(input logic [23:0] raw, so, sg, yo, yg);
    longint t;
    t = ((2 * longint'($signed(raw)) - longint'($signed(so))) * longint'(sg)) >>> 23;
    t = (longint'(yg) * (t - longint'($signed(yo)))) >>> 24;
    return sat(t);
  endfunction : model
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    chk({23'h0, reg_rvalid}, 24'h00_0001);
    chk(reg_rdata, e);
  endtask : rd
  task automatic pulse(input logic [23:0] raw);
    @(posedge clk);
    #1;
    conv_valid = 1'b1;
    conv_data = raw;
    @(posedge clk);
    #1;
    conv_valid = 1'b0;
  endtask : pulse
  task automatic conv(input logic [23:0] raw, input logic [23:0] e);
    pulse(raw);
    repeat (4) @(posedge clk);
    #1;
    chk({23'h0, data_valid}, 24'h00_0001);
    chk(data_out, e);
  endtask : conv
  // Upper command bits are set on purpose: only the low three may matter
  task automatic cal(input logic [2:0] cmd, input logic [23:0] r1, r2, input logic [1:0] rt);
    int n;
    wr(ADDR_CMD, {21'h0a_5a5a, cmd});
    for (int k = 0; k < ((cmd == CMD_SELF) ? 2 : 1); k++) begin
      n = 0;
      while (conv_start !== 1'b1 && n < 50) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk({23'h0, conv_start}, 24'h00_0001);
      chk({22'h0, cal_input_route}, {22'h0, (k == 1) ? 2'h2 : rt});
      pulse((k == 1) ? r2 : r1);
    end
    n = 0;
    while (cal_busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({23'h0, cal_busy}, 24'h00_0000);
    chk({22'h0, cal_input_route}, 24'h00_0000);
  endtask : cal
  task automatic t_reset();
    for (int a = 0; a < 17; a++) begin
      rd(a[7:0], ((a >= 2 && a <= 9) || a == 11 || a == 13) ? GAIN_UNITY : OFFSET_ZERO);
    end
    wr(ADDR_STATUS, 24'h00_0001);
    rd(ADDR_STATUS, 24'h00_0000);
  endtask : t_reset
  task automatic t_sys();
    amplifier_gain_setting = 3'h0;
    cal(CMD_ZERO_A, 24'h00_0005, 24'h00_0000, 2'h3);
    rd(ADDR_SYS_OFFSET_A, 24'h00_000a);
    cal(CMD_ZERO_B, 24'hff_fffd, 24'h00_0000, 2'h3);
    rd(ADDR_SYS_OFFSET_B, 24'hff_fffa);
    cal(CMD_SCALE_A, 24'h40_0005, 24'h00_0000, 2'h3);
    rd(ADDR_SYSTEM_GAIN_SET_A, gexp(64'sh40_0000));
    cal(CMD_SCALE_B, 24'h5f_fffd, 24'h00_0000, 2'h3);
    rd(ADDR_SYSTEM_GAIN_SET_B, gexp(64'sh60_0000));
  endtask : t_sys
  task automatic t_amp();
    amplifier_gain_setting = 3'h5;
    cal(CMD_AMP, 24'h30_0000, 24'h00_0000, 2'h2);
    rd(ADDR_SELF_GAIN0 + 8'h05, gexp(64'sh30_0000));
    rd(ADDR_SELF_GAIN0, GAIN_UNITY);
  endtask : t_amp
  task automatic t_self();
    amplifier_gain_setting = 3'h4;
    wr(ADDR_CMD, 24'h00_0002);
    chk({23'h0, cal_busy}, 24'h00_0000);
    cal(CMD_SELF, 24'h00_0003, 24'h40_0003, 2'h1);
    rd(ADDR_SELF_OFF, 24'h00_0006);
    rd(ADDR_SELF_GAIN0, gexp(64'sh40_0000));
    rd(ADDR_SELF_GAIN0 + 8'h04, GAIN_UNITY);
    rd(ADDR_SELF_GAIN0 + 8'h05, gexp(64'sh30_0000));
  endtask : t_self
  task automatic t_apply();
    logic [23:0] yo [4];
    logic [23:0] yg [4];
    logic [23:0] sg;
    yo = '{24'h00_0000, 24'h00_0004, 24'hff_fff0, 24'h00_0000};
    yg = '{GAIN_UNITY, 24'hc0_0000, 24'h60_0000, GAIN_UNITY};
    wr(ADDR_SELF_OFF, 24'h00_0002);
    wr(ADDR_SELF_GAIN0, GAIN_UNITY);
    wr(ADDR_SELF_GAIN0 + 8'h03, 24'h40_0000);
    wr(ADDR_SYS_OFFSET_A, yo[1]);
    wr(ADDR_SYSTEM_GAIN_SET_A, yg[1]);
    wr(ADDR_SYS_OFFSET_B, yo[2]);
    wr(ADDR_SYSTEM_GAIN_SET_B, yg[2]);
    rd(ADDR_SYS_OFFSET_B, yo[2]);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_SET_SELECT, {22'h0, s[1:0]});
      for (int g = 0; g < 4; g += 3) begin
        amplifier_gain_setting = g[2:0];
        sg = (g == 3) ? 24'h40_0000 : GAIN_UNITY;
        conv(24'h12_3457, model(24'h12_3457, 24'h00_0002, sg, yo[s], yg[s]));
        conv(24'hf0_0001, model(24'hf0_0001, 24'h00_0002, sg, yo[s], yg[s]));
      end
    end
  endtask : t_apply
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 24'h00_0000;
    conv_valid = 1'b0;
    conv_data = 24'h00_0000;
    amplifier_gain_setting = 3'h0;
    bad_count = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_sys();
    t_amp();
    t_self();
    t_apply();
    summarize();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule : testbench
bind adc_calibration_control cal_properties chk (.clk(clk), .resetn(resetn), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .amplifier_gain_setting(amplifier_gain_setting), .conv_valid(conv_valid),
  .conv_data(conv_data), .conv_start(conv_start), .cal_input_route(cal_input_route),
  .cal_busy(cal_busy), .data_out(data_out), .data_valid(data_valid));
`default_nettype wire
